// File: rtl/system_address_decoder.sv
// System address decoder: memory and I/O selects, DRAM bank control, refresh.
// Assumes bus pins come from another domain; the timer pulses the refresh pin.
//
// Function
// - Banks are nine one-bit parts, 64K or 256K
// - Only listed bank mixes, contiguous, 640 KB max
// - One refresh cycle per timer request
// - Row then column address, each with strobe
// - Memory decodes all twenty address lines
// - I/O decodes nine low lines only
// - Expansion ROM window at C0000, 192 KB
// - 48 KB system ROM ending at FFFFF
// - DMA select at 000 to 00F
// - Interrupt controller select at 020, 021
// - Interval timer select at 040 to 043
// - Parallel I/O unit select 060 to 063
// - DMA page registers at 080 to 083
// - NMI enable register at 0A0
// - Secondary serial port at 2F8 to 2FF
// - Primary serial port at 3F8 to 3FF
// - Printer port at 378 to 37F
// - 3B0 to 3BF left to monochrome card
// - 3D0 to 3DF left to colour card
// - 3F0 to 3F7 left to floppy card
// - Buffered 8-bit expansion bus to slots
`timescale 1ns/1ps
`include "sysdec_consts.svh"
module system_address_decoder (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [19:0] bus_addr,
  input wire logic memr_n,
  input wire logic memw_n,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic [2:0] bank_cfg_strap,
  input wire logic refresh_req,
  output sysdec_pkg::io_sel_t io_sel,
  output sysdec_pkg::mem_sel_t mem_sel,
  output sysdec_pkg::dram_t dram,
  output sysdec_pkg::exp_buf_t exp_buf,
  output logic mem_ready
);

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  typedef enum logic [2:0] {ST_IDLE, ST_ROW, ST_COL, ST_REF, ST_PRE} dram_state_t;

  logic [19:0] addr_s;
  logic [2:0] strap_s;
  sysdec_pkg::bus_cmd_t cmd_s;
  sysdec_pkg::bus_cmd_t cmd_pin;
  logic [1:0] strap_cnt_q;
  sysdec_pkg::bank_cfg_t cfg_q;
  sysdec_pkg::bank_hit_t hit;
  sysdec_pkg::io_sel_t io_sel_d;
  sysdec_pkg::mem_sel_t mem_sel_d;
  sysdec_pkg::exp_buf_t exp_buf_d;
  dram_state_t state_q;
  logic [3:0] cnt_q;
  logic [8:0] col_q;
  logic refresh_done_q;
  logic refresh_pending;
  logic [8:0] refresh_row;
  logic io_cmd;
  logic mem_cmd;
  logic ram_go;

  // Commands inverted before sampling so the reset value means idle
  assign cmd_pin = '{memr: !memr_n, memw: !memw_n, ior: !ior_n, iow: !iow_n};

  // Address and commands share one stage count, so they line up when sampled
  sync_bus #(.W(27)) u_bus_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pin_in({bus_addr, strap_s_pin(bank_cfg_strap), cmd_pin}),
    .sync_out({addr_s, strap_s, cmd_s})
  );

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Pass-through so the strap group reads clearly in the concatenation
  function automatic logic [2:0] strap_s_pin(input logic [2:0] s);
    strap_s_pin = s;
  endfunction

  // Compare on the nine decoded lines; A9 and above do not take part
  function automatic logic io_in(input logic [19:0] a, input logic [9:0] lo,
                                 input logic [9:0] hi);
    io_in = (a[8:0] >= lo[8:0]) && (a[8:0] <= hi[8:0]);
  endfunction

  // Size of each bank in 64 KB blocks for a given mix
  function automatic logic [2:0] bank_blocks(input sysdec_pkg::bank_cfg_t c,
                                             input logic [1:0] b);
    logic [11:0] t;
    t = 12'h000;
    case (c)
      sysdec_pkg::CFG_64_64_64_64: t = 12'o1111;
      sysdec_pkg::CFG_256_E_E_E: t = 12'o4000;
      sysdec_pkg::CFG_64_64_256_64: t = 12'o1141;
      sysdec_pkg::CFG_256_256_E_E: t = 12'o4400;
      sysdec_pkg::CFG_256_256_64_E: t = 12'o4410;
      sysdec_pkg::CFG_64_64_256_256: t = 12'o1144;
      sysdec_pkg::CFG_256_256_64_64: t = 12'o4411;
      default: t = 12'o1111;
    endcase
    bank_blocks = t[11 - 3 * b -: 3];
  endfunction

  // Banks stack upward from address zero in bank order
  function automatic sysdec_pkg::bank_hit_t bank_lookup(input logic [19:0] a,
      input sysdec_pkg::bank_cfg_t c);
    sysdec_pkg::bank_hit_t h;
    logic [3:0] base;
    logic [3:0] size;
    logic [3:0] rel;
    h = '0;
    base = 4'h0;
    for (int b = 0; b < 4; b++) begin
      size = {1'b0, bank_blocks(c, 2'(b))};
      rel = a[19:16] - base;
      if (!h.hit && size != 4'h0 && a[19:16] >= base && rel < size) begin
        h.hit = 1'b1;
        h.bank = 2'(b);
        h.deep = size[2];
        h.offset = {rel[1:0], a[15:0]};
      end
      base = base + size;
    end
    if (a[19:16] >= `MEM_RAM_TOP_BLK) begin
      h.hit = 1'b0;
    end
    bank_lookup = h;
  endfunction

  // ****************************************************************
  // Bank mix strap, caught once after reset release
  // ****************************************************************
  // Waits for the synchroniser to fill; the mix cannot change while running
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      strap_cnt_q <= 2'h0;
      cfg_q <= sysdec_pkg::CFG_64_64_64_64;
    end else if (strap_cnt_q != `STRAP_SETTLE) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == `STRAP_SETTLE - 2'h1) begin
        cfg_q <= (strap_s == 3'h7) ? sysdec_pkg::CFG_64_64_64_64
                                   : sysdec_pkg::bank_cfg_t'(strap_s);
      end
    end
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************
  assign io_cmd = cmd_s.ior || cmd_s.iow;
  assign mem_cmd = cmd_s.memr || cmd_s.memw;
  assign hit = bank_lookup(addr_s, cfg_q);

  // I/O selects; display and floppy card ranges have no entry here
  always_comb begin
    io_sel_d = '0;
    if (io_cmd) begin
      if (io_in(addr_s, `IO_DMA_LO, `IO_DMA_HI)) begin
        io_sel_d.dma = 1'b1;
      end else if (io_in(addr_s, `IO_INTR_LO, `IO_INTR_HI)) begin
        io_sel_d.intr_ctrl = 1'b1;
      end else if (io_in(addr_s, `IO_TIMER_LO, `IO_TIMER_HI)) begin
        io_sel_d.interval_timer = 1'b1;
      end else if (io_in(addr_s, `IO_PARALLEL_IO_LO, `IO_PARALLEL_IO_HI)) begin
        io_sel_d.parallel_io_unit = 1'b1;
      end else if (io_in(addr_s, `IO_PAGE_LO, `IO_PAGE_HI)) begin
        io_sel_d.dma_page = 1'b1;
      end else if (io_in(addr_s, `IO_NMI_EN, `IO_NMI_EN)) begin
        io_sel_d.nmi_enable = 1'b1;
      end else if (io_in(addr_s, `IO_SER2_LO, `IO_SER2_HI)) begin
        io_sel_d.secondary_serial_port = 1'b1;
      end else if (io_in(addr_s, `IO_LPT_LO, `IO_LPT_HI)) begin
        io_sel_d.printer_port = 1'b1;
      end else if (io_in(addr_s, `IO_SER1_LO, `IO_SER1_HI)) begin
        io_sel_d.primary_serial_port = 1'b1;
      end
    end
  end

  // Memory selects; ROMs answer reads only, the reserved area answers nothing
  always_comb begin
    mem_sel_d = '0;
    if (mem_cmd && hit.hit) begin
      mem_sel_d.ram = 1'b1;
    end else if (cmd_s.memr && addr_s >= `MEM_SYS_ROM_BASE) begin
      mem_sel_d.sys_rom = 1'b1;
    end else if (cmd_s.memr && addr_s >= `MEM_EXP_ROM_BASE &&
                 addr_s <= `MEM_EXP_ROM_TOP) begin
      mem_sel_d.exp_rom_window = 1'b1;
    end
  end

  // Slot buffers carry any cycle that no on-board select claims
  always_comb begin
    exp_buf_d = '0;
    exp_buf_d.addr_oe = io_cmd || mem_cmd;
    if ((io_cmd || mem_cmd) && io_sel_d == '0 && !mem_sel_d.ram &&
        !mem_sel_d.sys_rom) begin
      exp_buf_d.data_oe = 1'b1;
      exp_buf_d.data_to_slot = cmd_s.iow || cmd_s.memw;
    end
  end

  // Selects leave the block from flip-flops
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      io_sel <= '0;
      mem_sel <= '0;
      exp_buf <= '0;
    end else begin
      io_sel <= io_sel_d;
      mem_sel <= mem_sel_d;
      exp_buf <= exp_buf_d;
    end
  end

  // ****************************************************************
  // Refresh pacing
  // ****************************************************************
  refresh_pacer u_refresh (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .refresh_req(refresh_req),
    .refresh_done(refresh_done_q),
    .refresh_pending(refresh_pending),
    .refresh_row(refresh_row)
  );

  // ****************************************************************
  // DRAM sequencer
  // ****************************************************************
  assign ram_go = mem_cmd && hit.hit;
  assign mem_ready = (state_q == ST_COL);

  // Refresh takes priority at idle; an access in progress is never cut short
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      col_q <= 9'h000;
      refresh_done_q <= 1'b0;
      dram <= '{ras_n: 4'hf, cas_n: 1'b1, we_n: 1'b1, ma: 9'h000};
    end else begin
      refresh_done_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (refresh_pending) begin
            state_q <= ST_REF;
            cnt_q <= 4'(`REF_CYC - 1);
            dram.ras_n <= 4'h0;
            dram.ma <= refresh_row;
          end else if (ram_go) begin
            state_q <= ST_ROW;
            cnt_q <= 4'(`RCD_CYC - 1);
            dram.ras_n <= ~(4'h1 << hit.bank);
            dram.ma <= hit.deep ? hit.offset[8:0] : {1'b0, hit.offset[7:0]};
            col_q <= hit.deep ? hit.offset[17:9] : {1'b0, hit.offset[15:8]};
          end
        end
        ST_ROW: begin
          if (cnt_q == 4'h0) begin
            state_q <= ST_COL;
            dram.ma <= col_q;
            dram.cas_n <= 1'b0;
            dram.we_n <= !cmd_s.memw;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_COL: begin
          if (!mem_cmd) begin
            state_q <= ST_PRE;
            cnt_q <= 4'(`PRE_CYC - 1);
            dram <= '{ras_n: 4'hf, cas_n: 1'b1, we_n: 1'b1, ma: dram.ma};
          end
        end
        ST_REF: begin
          if (cnt_q == 4'h0) begin
            state_q <= ST_PRE;
            cnt_q <= 4'(`PRE_CYC - 1);
            dram.ras_n <= 4'hf;
            refresh_done_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_PRE: begin
          if (cnt_q == 4'h0) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_DMA_SEL: assert property (io_cmd && addr_s[8:4] == 5'h00 |=> io_sel.dma)
    else $error("DMA select missing");
  AST_INTR_SEL: assert property (io_sel.intr_ctrl |->
      $past(addr_s[8:1]) == 8'h10 && $past(io_cmd))
    else $error("Interrupt controller select outside its range");
  AST_TIMER_SEL: assert property (io_cmd && addr_s[8:2] == 7'h10 |=>
      io_sel.interval_timer)
    else $error("Timer select missing");
  AST_HIGH_BITS: assert property (io_cmd && addr_s[8:0] == 9'h1f8 |=>
      io_sel.primary_serial_port)
    else $error("Upper address bits changed an I/O decode");
  AST_NO_CMD: assert property (!io_cmd && !mem_cmd |=> io_sel == '0 && mem_sel == '0)
    else $error("Select without command");
  AST_MONO_FREE: assert property (io_cmd && addr_s[8:4] == 5'h1b |=>
      io_sel == '0 && exp_buf.data_oe)
    else $error("Monochrome range claimed on board");
  AST_RAM_LIMIT: assert property (mem_sel.ram |-> $past(addr_s) < `MEM_RSV_BASE)
    else $error("RAM selected above 640 KB");
  AST_SYS_ROM: assert property (cmd_s.memr && addr_s >= `MEM_SYS_ROM_BASE |=>
      mem_sel.sys_rom && !mem_sel.ram)
    else $error("System ROM not selected");
  AST_EXP_ROM: assert property (cmd_s.memr && addr_s[19:18] == 2'h3 &&
      addr_s[17:16] != 2'h3 |=> mem_sel.exp_rom_window)
    else $error("Expansion ROM window not selected");
  AST_REFRESH: assert property ($rose(refresh_pending) |-> ##[1:200] state_q == ST_REF)
    else $error("Refresh request not served");
  AST_ROW_FIRST: assert property ($fell(dram.cas_n) |->
      $past(dram.ras_n) != 4'hf && $past(state_q) == ST_ROW)
    else $error("Column strobe without row strobe");
  AST_ONE_BANK: assert property (state_q == ST_COL |-> $onehot(~dram.ras_n))
    else $error("More than one bank strobed for an access");

  COV_REFRESH: cover property (state_q == ST_REF ##[1:20] refresh_done_q);
  COV_RAM_ACCESS: cover property (state_q == ST_ROW ##[1:8] state_q == ST_COL);
  COV_ROM_READ: cover property (mem_sel.sys_rom);

endmodule

// File: rtl/sysdec_consts.svh
// Address map, I/O map and DRAM timing constants for the system address decoder.
// Assumes a 100 MHz system clock; included by its bare name.
`ifndef SYSDEC_CONSTS_SVH
`define SYSDEC_CONSTS_SVH

// ****************************************************************
// Memory map (20-bit byte addresses)
// ****************************************************************
`define MEM_RAM_TOP_BLK 4'ha
`define MEM_RSV_BASE 20'ha_0000
`define MEM_RSV_TOP 20'hb_ffff
`define MEM_EXP_ROM_BASE 20'hc_0000
`define MEM_EXP_ROM_TOP 20'he_ffff
`define MEM_SYS_ROM_BASE 20'hf_4000
`define MEM_SYS_ROM_TOP 20'hf_ffff

// ****************************************************************
// I/O map, printed 10-bit values; only the low nine bits decode
// ****************************************************************
`define IO_DMA_LO 10'h000
`define IO_DMA_HI 10'h00f
`define IO_INTR_LO 10'h020
`define IO_INTR_HI 10'h021
`define IO_TIMER_LO 10'h040
`define IO_TIMER_HI 10'h043
`define IO_PARALLEL_IO_LO 10'h060
`define IO_PARALLEL_IO_HI 10'h063
`define IO_PAGE_LO 10'h080
`define IO_PAGE_HI 10'h083
`define IO_NMI_EN 10'h0a0
`define IO_SER2_LO 10'h2f8
`define IO_SER2_HI 10'h2ff
`define IO_LPT_LO 10'h378
`define IO_LPT_HI 10'h37f
`define IO_SER1_LO 10'h3f8
`define IO_SER1_HI 10'h3ff
`define IO_MONO_LO 10'h3b0
`define IO_MONO_HI 10'h3bf
`define IO_COLOR_LO 10'h3d0
`define IO_COLOR_HI 10'h3df
`define IO_FLOPPY_LO 10'h3f0
`define IO_FLOPPY_HI 10'h3f7

// ****************************************************************
// DRAM timing, least times rounded up to whole cycles
// ****************************************************************
`define CLK_PERIOD_NS 10
`define RAS_TO_CAS_NS 30
`define PRECHARGE_NS 80
`define REFRESH_RAS_NS 120
`define RCD_CYC ((`RAS_TO_CAS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRE_CYC ((`PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REF_CYC ((`REFRESH_RAS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRAP_SETTLE 2'h3

`endif

// File: rtl/sysdec_pkg.sv
// Types shared by the system address decoder and its helpers.
// Assumes nothing beyond a SystemVerilog compiler.
package sysdec_pkg;

  // ****************************************************************
  // Bank mixes that the board accepts, bank 0 first
  // ****************************************************************
  typedef enum logic [2:0] {
    CFG_64_64_64_64,
    CFG_256_E_E_E,
    CFG_64_64_256_64,
    CFG_256_256_E_E,
    CFG_256_256_64_E,
    CFG_64_64_256_256,
    CFG_256_256_64_64
  } bank_cfg_t;

  // Bus commands, active high inside the block
  typedef struct packed {
    logic memr;
    logic memw;
    logic ior;
    logic iow;
  } bus_cmd_t;

  typedef struct packed {
    logic dma;
    logic intr_ctrl;
    logic interval_timer;
    logic parallel_io_unit;
    logic dma_page;
    logic nmi_enable;
    logic secondary_serial_port;
    logic printer_port;
    logic primary_serial_port;
  } io_sel_t;

  typedef struct packed {
    logic ram;
    logic exp_rom_window;
    logic sys_rom;
  } mem_sel_t;

  typedef struct packed {
    logic [3:0] ras_n;
    logic cas_n;
    logic we_n;
    logic [8:0] ma;
  } dram_t;

  typedef struct packed {
    logic addr_oe;
    logic data_oe;
    logic data_to_slot;
  } exp_buf_t;

  typedef struct packed {
    logic hit;
    logic [1:0] bank;
    logic deep;
    logic [17:0] offset;
  } bank_hit_t;

endpackage

// File: rtl/sync_bus.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are active high and idle low at reset.
`timescale 1ns/1ps
module sync_bus #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= pin_in;
      sync_out <= meta_q;
    end
  end

endmodule

// File: rtl/refresh_pacer.sv
// Turns the periodic timer refresh request into a pending flag and a row counter.
// Assumes the request pin is asynchronous and pulses once per refresh period.
`timescale 1ns/1ps
module refresh_pacer (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic refresh_req,
  input wire logic refresh_done,
  output logic refresh_pending,
  output logic [8:0] refresh_row
);

  logic req_s;
  logic req_seen_q;
  logic req_rise;

  sync_bus #(.W(1)) u_req_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pin_in(refresh_req),
    .sync_out(req_s)
  );

  // Edge detect looks only at the second synchroniser stage
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      req_seen_q <= 1'b0;
    end else begin
      req_seen_q <= req_s;
    end
  end
  assign req_rise = req_s && !req_seen_q;

  // New request wins over the done pulse; two requests before service merge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      refresh_pending <= 1'b0;
    end else if (req_rise) begin
      refresh_pending <= 1'b1;
    end else if (refresh_done) begin
      refresh_pending <= 1'b0;
    end
  end

  // Nine row bits cover both 64 K and 256 K parts
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      refresh_row <= 9'h000;
    end else if (refresh_done) begin
      refresh_row <= refresh_row + 9'h001;
    end
  end

endmodule

// File: testbench/host_bus_model.sv
// Behavioural bus master standing in for the processor, DMA and refresh timer.
// Assumes the bench calls its tasks from one process; command pins idle high, refresh request low.
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk_sys,
  output logic [19:0] bus_addr,
  output logic memr_n,
  output logic memw_n,
  output logic ior_n,
  output logic iow_n,
  output logic refresh_req
);
  // ****************************************************************
  // Idle bus at time zero
  // ****************************************************************
  initial begin
    bus_addr = 20'h0_0000;
    {memr_n, memw_n, ior_n, iow_n} = 4'hf;
    refresh_req = 1'h0;
  end

  // Address goes out a cycle before the command, both held until stop
  task automatic start(input logic [19:0] a, input logic [1:0] k);
    @(posedge clk_sys);
    #1;
    bus_addr = a;
    @(posedge clk_sys);
    #1;
    memr_n = (k != 2'h0);
    memw_n = (k != 2'h1);
    ior_n = (k != 2'h2);
    iow_n = (k != 2'h3);
  endtask

  // Released address is inverted so a stale value never looks valid
  task automatic stop();
    @(posedge clk_sys);
    #1;
    {memr_n, memw_n, ior_n, iow_n} = 4'hf;
    @(posedge clk_sys);
    #1;
    bus_addr = ~bus_addr;
  endtask

  // Timer request level, one change per call
  task automatic refresh(input logic lvl);
    @(posedge clk_sys);
    #1;
    refresh_req = lvl;
  endtask
endmodule

// File: testbench/system_address_decoder_test.sv
// Self-checking bench for the system address decoder.
// Assumes the host model drives all bus pins and the strap is set during reset.
`timescale 1ns/1ps
module system_address_decoder_test;
  logic clk_sys = 1'h0;
  logic reset_n = 1'h0;
  logic [2:0] bank_cfg_strap = 3'h0;
  logic [19:0] bus_addr;
  logic memr_n, memw_n, ior_n, iow_n, refresh_req, mem_ready;
  sysdec_pkg::io_sel_t io_sel;
  sysdec_pkg::mem_sel_t mem_sel;
  sysdec_pkg::dram_t dram;
  sysdec_pkg::exp_buf_t exp_buf;
  int error_cnt = 0;
  int checks = 0;
  // Printed I/O addresses; odd entries get junk in the upper bits
  localparam logic [9:0] IO_A [24] = '{10'h000, 10'h00f, 10'h020, 10'h021, 10'h040, 10'h043,
    10'h060, 10'h063, 10'h080, 10'h083, 10'h0a0, 10'h2f8, 10'h2ff, 10'h378, 10'h37f, 10'h3f8,
    10'h3ff, 10'h3b0, 10'h3bf, 10'h3d0, 10'h3df, 10'h3f0, 10'h3f7, 10'h010};
  localparam logic [8:0] IO_E [24] = '{9'h100, 9'h100, 9'h080, 9'h080, 9'h040, 9'h040, 9'h020,
    9'h020, 9'h010, 9'h010, 9'h008, 9'h004, 9'h004, 9'h002, 9'h002, 9'h001, 9'h001, 9'h000,
    9'h000, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000};
  localparam logic [19:0] MEM_A [13] = '{20'h0_0000, 20'h3_ffff, 20'h4_0000, 20'ha_0000,
    20'hb_ffff, 20'hc_0000, 20'he_ffff, 20'hf_0000, 20'hf_3fff, 20'hf_4000, 20'hf_ffff,
    20'hf_4000, 20'hc_0000};
  localparam logic [1:0] MEM_K [13] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0,
    2'h0, 2'h0, 2'h0, 2'h1, 2'h1};
  localparam logic [2:0] MEM_E [13] = '{3'h4, 3'h4, 3'h0, 3'h0, 3'h0, 3'h2, 3'h2, 3'h0,
    3'h0, 3'h1, 3'h1, 3'h0, 3'h0};
  localparam logic [19:0] CFG_TOP [8] = '{20'h4_0000, 20'h4_0000, 20'h7_0000, 20'h8_0000,
    20'h9_0000, 20'ha_0000, 20'ha_0000, 20'h4_0000};

  // ****************************************************************
  // Clock, partner, design
  // ****************************************************************
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  host_bus_model u_host (.clk_sys(clk_sys), .bus_addr(bus_addr), .memr_n(memr_n),
    .memw_n(memw_n), .ior_n(ior_n), .iow_n(iow_n), .refresh_req(refresh_req));

  system_address_decoder u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .bus_addr(bus_addr),
    .memr_n(memr_n), .memw_n(memw_n), .ior_n(ior_n), .iow_n(iow_n),
    .bank_cfg_strap(bank_cfg_strap), .refresh_req(refresh_req), .io_sel(io_sel),
    .mem_sel(mem_sel), .dram(dram), .exp_buf(exp_buf), .mem_ready(mem_ready));

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic check(input logic [19:0] got, input logic [19:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Strap must be steady before release; first request waits past edge 5
  task automatic do_reset(input logic [2:0] cfg);
    #1;
    reset_n = 1'h0;
    bank_cfg_strap = cfg;
    repeat (10) @(posedge clk_sys);
    #1;
    reset_n = 1'h1;
    repeat (5) @(posedge clk_sys);
  endtask

  // Decode shows three edges after the command, so sample after the fourth
  task automatic io_probe(input logic [19:0] a, input logic [1:0] k, input logic [8:0] e);
    u_host.start(a, k);
    repeat (4) @(posedge clk_sys);
    #1;
    check(20'(io_sel), 20'(e), "io select");
    check(20'(io_sel), 20'(e), "io map upper");
    check(20'(mem_sel), 20'h0_0000, "mem select in io cycle");
    check(20'(exp_buf), 20'({1'h1, e == 9'h000, e == 9'h000 && k == 2'h3}),
      "slot buffers");
    u_host.stop();
    repeat (4) @(posedge clk_sys);
  endtask

  // Long tail lets any DRAM cycle finish its precharge
  task automatic mem_probe(input logic [19:0] a, input logic [1:0] k, input logic [2:0] e);
    u_host.start(a, k);
    repeat (4) @(posedge clk_sys);
    #1;
    check(20'(mem_sel), 20'(e), "mem select");
    u_host.stop();
    repeat (16) @(posedge clk_sys);
  endtask

  task automatic dram_probe(input logic [19:0] a, input logic [1:0] k, input logic [3:0] r,
      input logic [8:0] row, input logic [8:0] col);
    u_host.start(a, k);
    repeat (4) @(posedge clk_sys);
    #1;
    check(20'({dram.ras_n, dram.cas_n, dram.ma}), 20'({r, 1'h1, row}), "row phase");
    repeat (3) @(posedge clk_sys);
    #1;
    check(20'({dram.cas_n, dram.we_n, mem_ready, dram.ma}),
      20'({1'h0, k == 2'h0, 1'h1, col}), "column phase");
    u_host.stop();
    repeat (4) @(posedge clk_sys);
    #1;
    check(20'({dram.ras_n, dram.cas_n, mem_ready}), 20'h0_003e, "strobes off");
    repeat (12) @(posedge clk_sys);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_io_map();
    for (int i = 0; i < 24; i++) begin
      io_probe({(i % 2 == 1) ? 10'h2a5 : 10'h000, IO_A[i]}, 2'(2 + i % 2), IO_E[i]);
    end
    io_probe(20'hc_0000, 2'h2, 9'h100);
    $display("test io_map done");
  endtask

  task automatic test_mem_map();
    for (int i = 0; i < 13; i++) begin
      mem_probe(MEM_A[i], MEM_K[i], MEM_E[i]);
    end
    // With no command held nothing may be selected
    repeat (4) @(posedge clk_sys);
    #1;
    check(20'({io_sel, mem_sel, exp_buf[2]}), 20'h0_0000, "idle selects");
    $display("test mem_map done");
  endtask

  task automatic test_dram();
    dram_probe(20'h1_5634, 2'h0, 4'hd, 9'h034, 9'h056);
    dram_probe(20'h3_ffff, 2'h1, 4'h7, 9'h0ff, 9'h0ff);
    $display("test dram done");
  endtask

  task automatic test_refresh();
    int n;
    logic [8:0] row;
    row = 9'h000;
    for (int p = 0; p < 2; p++) begin
      u_host.refresh(1'h1);
      n = 0;
      while (dram.ras_n !== 4'h0 && n < 20) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      check(20'(dram.ras_n), 20'h0_0000, "refresh strobe");
      if (p == 1) begin
        check(20'(dram.ma), 20'(row + 9'h001), "refresh row step");
      end
      row = dram.ma;
      n = 0;
      while (dram.ras_n === 4'h0 && n < 30) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      check(20'(n), 20'h0_000c, "refresh hold");
      u_host.refresh(1'h0);
      repeat (12) @(posedge clk_sys);
    end
    $display("test refresh done");
  endtask

  // Every strap code: last RAM byte hits, first byte above the total misses
  task automatic test_configs();
    for (int c = 0; c < 8; c++) begin
      do_reset(3'(c));
      mem_probe(CFG_TOP[c] - 20'h0_0001, 2'h0, 3'h4);
      mem_probe(CFG_TOP[c], 2'h0, 3'h0);
    end
    do_reset(3'h1);
    dram_probe(20'h2_5634, 2'h0, 4'he, 9'h034, 9'h12b);
    $display("test configs done");
  endtask

  // ****************************************************************
  // Verdict and sequence
  // ****************************************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog sized at over twenty times the expected run
  initial begin
    #300000;
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    close_out();
  end

  initial begin
    do_reset(3'h0);
    test_io_map();
    test_mem_map();
    test_dram();
    test_refresh();
    test_configs();
    close_out();
  end
endmodule
